/* dv/ser_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host side spi master, mode 0, clock only inside frames
module ser_host_model
(
  // spi pins
  output logic      sclk,
  output logic      ssN,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] rxq [$];

  // link idles with select high and clock low
  initial
  begin
    sclk = 1'b0;
    ssN  = 1'b1;
    mosi = 1'b1;
  end

  // one frame, msb first, 6 ns link clock, bytes spaced apart
  task automatic frame(input logic [7:0] tx [$]);
    logic [7:0] r;
    rxq.delete();
    ssN = 1'b0;
    #6;
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        mosi = tx[i][k];
        #3;
        r[k] = miso;
        sclk = 1'b1;
        #3;
        sclk = 1'b0;
      end
      rxq.push_back(r);
      #40;
    end
    ssN  = 1'b1;
    mosi = ~mosi; // released line shows no stale level
  endtask
endmodule

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench for the error response block
module testbench;
  import ser_pkg::*;

  typedef ser_byte_t ser_bq_t [$];

  logic        ref_clk;
  logic        srst;
  logic        sclk;
  logic        ssN;
  logic        mosi;
  logic        miso;
  logic        misoOe;
  logic        chgN;
  logic        reqValid;
  ser_byte_t   reqOpcode;
  logic [15:0] reqAddr;
  logic [15:0] reqLen;
  logic        rspValid;
  ser_byte_t   rspOpcode;
  logic [15:0] rspAddr;
  logic [15:0] rspLen;
  logic        commsErr;
  int          bad_count = 0;
  int          total_checks = 0;
  int          reqSeen = 0;
  int          errSeen = 0;
  ser_bq_t     zq = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // core clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  ser_error_resp i_ser_error_resp
  (
    .ref_clk(ref_clk), .srst(srst), .sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(miso),
    .misoOe(misoOe), .chgN(chgN), .reqValid(reqValid), .reqOpcode(reqOpcode),
    .reqAddr(reqAddr), .reqLen(reqLen), .rspValid(rspValid), .rspOpcode(rspOpcode),
    .rspAddr(rspAddr), .rspLen(rspLen), .comms_error_flag(commsErr)
  );

  ser_host_model i_ser_host_model
  (
    .sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(miso)
  );

  // count accepted requests and data error pulses
  always @(posedge ref_clk)
  begin
    if (reqValid === 1'b1)
      reqSeen <= reqSeen + 1;
    if (commsErr === 1'b1)
      errSeen <= errSeen + 1;
  end

  // ==========================================================
  // helpers
  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // msb first, poly 0x07, start 0x00
  function automatic ser_byte_t crc8(input ser_bq_t q);
    ser_byte_t c;
    c = 8'h00;
    foreach (q[i])
    begin
      c = c ^ q[i];
      for (int k = 0; k < 8; k++)
        c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // header with crc, flip spoils the crc on purpose
  function automatic ser_bq_t mk(input ser_byte_t op, input logic [15:0] a, input logic [15:0] l,
                                 input ser_byte_t flip);
    ser_bq_t q;
    q = '{op, a[7:0], a[15:8], l[7:0], l[15:8]};
    q.push_back(crc8(q) ^ flip);
    return q;
  endfunction

  task automatic waitChg;
    for (int n = 0; n < 300 && chgN !== 1'b0; n++)
      @(negedge ref_clk);
    chk("chgN", 16'h0000, {15'h0000, chgN});
    if (chgN !== 1'b0)
      stop_test();
  endtask

  task automatic waitReq(input int r0);
    for (int n = 0; n < 30 && reqSeen == r0; n++)
      @(negedge ref_clk);
    chk("reqValid count", 16'(r0 + 1), 16'(reqSeen));
    if (reqSeen == r0)
      stop_test();
  endtask

  task automatic appAnswer(input ser_byte_t op, input logic [15:0] a, input logic [15:0] l);
    @(negedge ref_clk);
    rspValid  = 1'b1;
    rspOpcode = op;
    rspAddr   = a;
    rspLen    = l;
    @(negedge ref_clk);
    rspValid  = 1'b0;
  endtask

  // shift tx out and compare the six bytes coming back
  task automatic collect(input ser_byte_t op, input logic [15:0] a, input logic [15:0] l,
                         input ser_bq_t tx);
    ser_bq_t e;
    e = mk(op, a, l, 8'h00);
    @(negedge ref_clk);
    // probe the pins while the readout frame is open
    fork
      i_ser_host_model.frame(tx);
      begin
        #20;
        chk("misoOe in frame", 16'h0001, {15'h0000, misoOe});
        #80;
        chk("chgN in frame", 16'h0001, {15'h0000, chgN});
      end
    join
    foreach (e[i])
      chk("response byte", {8'h00, e[i]}, {8'h00, i_ser_host_model.rxq[i]});
    repeat (4) @(negedge ref_clk);
    chk("chgN after readout", 16'h0001, {15'h0000, chgN});
    chk("misoOe after frame", 16'h0000, {15'h0000, misoOe});
  endtask

  // ==========================================================
  // scenarios
  task automatic s_badcrc;
    int r0;
    r0 = reqSeen;
    i_ser_host_model.frame(mk(8'h02, 16'h1234, 16'h000f, 8'h5a));
    waitChg();
    chk("reqValid count", 16'(r0), 16'(reqSeen));
    collect(8'h08, 16'h1234, 16'h000f, zq);
  endtask

  task automatic s_unknown;
    i_ser_host_model.frame(mk(8'h33, 16'h00a5, 16'h0102, 8'h00));
    waitChg();
    collect(8'h04, 16'h00a5, 16'h0102, zq);
  endtask

  task automatic s_clash;
    int r0;
    r0 = reqSeen;
    i_ser_host_model.frame(mk(8'h02, 16'h0040, 16'h0005, 8'h00));
    waitReq(r0);
    chk("reqOpcode", 16'h0002, {8'h00, reqOpcode});
    chk("reqAddr", 16'h0040, reqAddr);
    chk("reqLen", 16'h0005, reqLen);
    appAnswer(8'h82, 16'h0040, 16'h0005);
    waitChg();
    r0 = reqSeen;
    collect(8'h82, 16'h0040, 16'h0005, mk(8'h01, 16'h0099, 16'h0005, 8'h00));
    i_ser_host_model.frame(mk(8'h02, 16'h0077, 16'h0003, 8'h00));
    waitChg();
    chk("reqValid count", 16'(r0), 16'(reqSeen));
    collect(8'h04, 16'h0077, 16'h0003, zq);
  endtask

  task automatic s_write(input ser_byte_t flip, input int expErr);
    int      r0;
    int      e0;
    ser_bq_t q;
    r0 = reqSeen;
    e0 = errSeen;
    q  = mk(8'h01, 16'h0010, 16'h0003, 8'h00);
    q.push_back(8'haa);
    q.push_back(8'h55);
    q.push_back(crc8('{8'haa, 8'h55}) ^ flip);
    i_ser_host_model.frame(q);
    waitReq(r0);
    chk("comms error count", 16'(e0 + expErr), 16'(errSeen));
    appAnswer(8'h81, 16'h0010, 16'h0003);
    waitChg();
    collect(8'h81, 16'h0010, 16'h0003, zq);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    srst      = 1'b1;
    rspValid  = 1'b0;
    rspOpcode = 8'h00;
    rspAddr   = 16'h0000;
    rspLen    = 16'h0000;
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    s_badcrc();
    s_unknown();
    s_clash();
    s_write(8'h00, 0);
    s_write(8'h01, 1);
    stop_test();
  end
endmodule

`default_nettype wire

/* logic/ser_crc8.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_defs.svh"

// ==========================================================
// one byte step of the msb-first crc-8
module ser_crc8
(
  // running value and next byte
  input  wire ser_pkg::ser_byte_t crcIn,
  input  wire ser_pkg::ser_byte_t dataIn,
  // updated value
  output ser_pkg::ser_byte_t      crcOut
);
  import ser_pkg::*;

  ser_byte_t stageVal [0:8];

  assign stageVal[0] = crcIn ^ dataIn;

  // one shift and conditional xor per bit
  for (genvar i = 0; i < 8; i++)
  begin : g_bit
    assign stageVal[i+1] = stageVal[i][7] ? ((stageVal[i] << 1) ^ `SER_CRC_POLY)
                                          : (stageVal[i] << 1);
  end

  assign crcOut = stageVal[8];

endmodule
`default_nettype wire

/* logic/ser_defs.svh */
`ifndef SER_DEFS_SVH
`define SER_DEFS_SVH

// ==========================================================
// request and response opcodes
`define SER_OP_WRITE    8'h01
`define SER_OP_READ     8'h02
`define SER_OP_INVALID  8'h04
`define SER_OP_BADCRC   8'h08

// ==========================================================
// header layout, byte positions in a frame
`define SER_POS_OPC     16'h0000
`define SER_POS_ADDR_LO 16'h0001
`define SER_POS_ADDR_HI 16'h0002
`define SER_POS_LEN_LO  16'h0003
`define SER_POS_LEN_HI  16'h0004
`define SER_POS_CRC     16'h0005
`define SER_HDR_BYTES   16'h0006
`define SER_LAST_FIELD  3'h4
`define SER_RSP_BYTES   3'h6

// ==========================================================
// crc-8 polynomial and start value
`define SER_CRC_POLY    8'h07
`define SER_CRC_INIT    8'h00

`endif

/* logic/ser_error_resp.sv */
// Contract
// - rejected request answered 0x04 with its address
// - invalid answer length is requested data count
// - bad header crc answered with opcode 0x08
// - crc answer carries last address and length
// - data crc fault goes to command processor
// - clash frame shifts pending response, drops request
// - response fully staged before interrupt rises
// - request after clash answered with 0x04
// - unknown opcode also answered with 0x04
// - interrupt held off while select is low
// - header: address, length low first, then crc
`timescale 1ns/1ps
`default_nettype none
`include "ser_defs.svh"

module ser_error_resp
(
  // core clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // spi pins
  input  wire logic                  sclk,
  input  wire logic                  ssN,
  input  wire logic                  mosi,
  output logic                       miso,
  output logic                       misoOe,
  output logic                       chgN,
  // accepted request towards the application
  output logic                       reqValid,
  output ser_pkg::ser_byte_t         reqOpcode,
  output logic [15:0]                reqAddr,
  output logic [15:0]                reqLen,
  // application answer to stage
  input  wire logic                  rspValid,
  input  wire ser_pkg::ser_byte_t    rspOpcode,
  input  wire logic [15:0]           rspAddr,
  input  wire logic [15:0]           rspLen,
  // message to the command_processor_object
  output logic                       comms_error_flag
);
  import ser_pkg::*;

  typedef struct packed {
    logic       ssMeta;
    logic       ssSync;
    logic       ssPrev;
    logic       tglMeta;
    logic       tglSync;
    logic       tglPrev;
    logic       rstLink;
    logic       frame;
    logic       clashFrame;
    logic [15:0] byteCnt;
    ser_byte_t  opc;
    logic [15:0] addr;
    logic [15:0] len;
    ser_byte_t  hcrcRx;
    ser_byte_t  hcrc;
    ser_byte_t  dcrc;
    ser_byte_t  dcrcPrev;
    ser_byte_t  dLast;
    logic       clash;
    ser_state_t state;
    logic [2:0] stIdx;
    ser_rsp_t   rsp;
    ser_byte_t  tcrc;
    logic       irqOn;
    logic       commsErr;
    logic       reqValid;
  } ser_core_t;

  ser_core_t q_ff, nxt_q;

  ser_byte_t linkByte;
  logic      linkTgl;
  ser_byte_t rxCrcIn;
  ser_byte_t rxCrcOut;
  ser_byte_t txCrcOut;
  logic      frmStart;
  logic      frmEnd;
  logic      newByte;
  logic      hdrBad;
  logic      opcOk;
  logic      dataBad;

  // ==========================================================
  // link side and crc steps
  ser_spi_link u_link
  (
    .sclk    (sclk),
    .ssN     (ssN),
    .mosi    (mosi),
    .miso    (miso),
    .misoOe  (misoOe),
    .rstLink (q_ff.rstLink),
    .txRsp   (q_ff.rsp),
    .rxByte  (linkByte),
    .rxTgl   (linkTgl)
  );

  // header crc while in the header, data crc after it
  assign rxCrcIn = (q_ff.byteCnt < `SER_POS_CRC) ? q_ff.hcrc : q_ff.dcrc;

  ser_crc8 u_rx_crc
  (
    .crcIn  (rxCrcIn),
    .dataIn (linkByte),
    .crcOut (rxCrcOut)
  );

  ser_crc8 u_tx_crc
  (
    .crcIn  (q_ff.tcrc),
    .dataIn (q_ff.rsp[q_ff.stIdx]),
    .crcOut (txCrcOut)
  );

  // ==========================================================
  // frame events and request checks
  assign frmStart = q_ff.ssPrev && !q_ff.ssSync;
  assign frmEnd = !q_ff.ssPrev && q_ff.ssSync;
  assign newByte = q_ff.frame && (q_ff.tglSync != q_ff.tglPrev);
  assign hdrBad = (q_ff.byteCnt < `SER_HDR_BYTES) || (q_ff.hcrc != q_ff.hcrcRx);
  assign opcOk = (q_ff.opc == `SER_OP_READ) || (q_ff.opc == `SER_OP_WRITE);
  assign dataBad = (q_ff.opc == `SER_OP_WRITE) && (q_ff.byteCnt > `SER_HDR_BYTES)
                   && (q_ff.dcrcPrev != q_ff.dLast);

  // header bytes without crc, in send order
  function automatic ser_rsp_t mkRsp(input ser_byte_t op, input logic [15:0] a, input logic [15:0] l);
    mkRsp = {8'h00, l[15:8], l[7:0], a[15:8], a[7:0], op};
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.ssMeta = ssN;
    nxt_q.ssSync = q_ff.ssMeta;
    nxt_q.ssPrev = q_ff.ssSync;
    nxt_q.tglMeta = linkTgl;
    nxt_q.tglSync = q_ff.tglMeta;
    nxt_q.tglPrev = q_ff.tglSync;
    nxt_q.rstLink = 1'b0;
    nxt_q.commsErr = 1'b0;
    nxt_q.reqValid = 1'b0;

    // capture header fields and running crcs
    if (newByte)
    begin
      case (q_ff.byteCnt)
        `SER_POS_OPC:     nxt_q.opc = linkByte;
        `SER_POS_ADDR_LO: nxt_q.addr[7:0] = linkByte;
        `SER_POS_ADDR_HI: nxt_q.addr[15:8] = linkByte;
        `SER_POS_LEN_LO:  nxt_q.len[7:0] = linkByte;
        `SER_POS_LEN_HI:  nxt_q.len[15:8] = linkByte;
        `SER_POS_CRC:     nxt_q.hcrcRx = linkByte;
        default:
        begin
          nxt_q.dcrcPrev = q_ff.dcrc;
          nxt_q.dcrc = rxCrcOut;
          nxt_q.dLast = linkByte;
        end
      endcase
      if (q_ff.byteCnt < `SER_POS_CRC)
        nxt_q.hcrc = rxCrcOut;
      if (q_ff.byteCnt != 16'hffff)
        nxt_q.byteCnt = q_ff.byteCnt + 16'h0001;
    end

    // a frame opening while anything is pending is a readout
    if (frmStart)
    begin
      nxt_q.frame = 1'b1;
      nxt_q.clashFrame = (q_ff.state != SER_IDLE);
      nxt_q.byteCnt = 16'h0000;
      nxt_q.opc = 8'h00;
      nxt_q.hcrc = `SER_CRC_INIT;
      nxt_q.dcrc = `SER_CRC_INIT;
      nxt_q.dcrcPrev = `SER_CRC_INIT;
    end

    case (q_ff.state)
      SER_IDLE:
      begin
        if (frmEnd && !q_ff.clashFrame)
        begin
          if (hdrBad)
          begin
            nxt_q.rsp = mkRsp(`SER_OP_BADCRC, q_ff.addr, q_ff.len);
            nxt_q.state = SER_STAGE;
          end
          else if (q_ff.clash || !opcOk)
          begin
            nxt_q.rsp = mkRsp(`SER_OP_INVALID, q_ff.addr, q_ff.len);
            nxt_q.clash = 1'b0;
            nxt_q.state = SER_STAGE;
          end
          else
          begin
            nxt_q.reqValid = 1'b1;
            nxt_q.commsErr = dataBad;
            nxt_q.state = SER_WAIT_APP;
          end
        end
      end
      SER_WAIT_APP:
      begin
        if (rspValid)
        begin
          nxt_q.rsp = mkRsp(rspOpcode, rspAddr, rspLen);
          nxt_q.state = SER_STAGE;
        end
      end
      SER_STAGE:
      begin
        // crc over bytes 0 to 4, then the header is complete
        nxt_q.tcrc = txCrcOut;
        nxt_q.stIdx = q_ff.stIdx + 3'h1;
        if (q_ff.stIdx == `SER_LAST_FIELD)
        begin
          nxt_q.rsp[5] = txCrcOut;
          nxt_q.state = SER_READY;
        end
      end
      SER_READY:
      begin
        // any frame here carries the response out
        if (frmEnd && q_ff.clashFrame)
          nxt_q.state = SER_IDLE;
      end
      default:
        nxt_q.state = SER_IDLE;
    endcase

    // a request sent on top of a pending answer is remembered
    if (frmEnd)
    begin
      nxt_q.frame = 1'b0;
      if (q_ff.clashFrame && (q_ff.state != SER_READY || opcOk))
        nxt_q.clash = 1'b1;
    end

    if (nxt_q.state != SER_STAGE)
    begin
      nxt_q.stIdx = 3'h0;
      nxt_q.tcrc = `SER_CRC_INIT;
    end

    // interrupt only with a staged header and no frame open
    nxt_q.irqOn = (nxt_q.state == SER_READY) && (q_ff.state == SER_READY)
                  && !nxt_q.frame && !frmStart;
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q_ff <= '0;
      q_ff.ssMeta <= 1'b1;
      q_ff.ssSync <= 1'b1;
      q_ff.ssPrev <= 1'b1;
      q_ff.rstLink <= 1'b1;
      q_ff.state <= SER_IDLE;
      q_ff.hcrc <= `SER_CRC_INIT;
      q_ff.dcrc <= `SER_CRC_INIT;
      q_ff.dcrcPrev <= `SER_CRC_INIT;
      q_ff.tcrc <= `SER_CRC_INIT;
    end
    else
      q_ff <= nxt_q;
  end

  // ==========================================================
  // outputs
  assign chgN = ~q_ff.irqOn;
  assign reqValid = q_ff.reqValid;
  assign reqOpcode = q_ff.opc;
  assign reqAddr = q_ff.addr;
  assign reqLen = q_ff.len;
  assign comms_error_flag = q_ff.commsErr;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  inv_answer_a : assert property (frmEnd && !q_ff.clashFrame && q_ff.state == SER_IDLE && !hdrBad && !opcOk
    |=> q_ff.rsp[0] == `SER_OP_INVALID && {q_ff.rsp[2], q_ff.rsp[1]} == $past(q_ff.addr))
    else $error("invalid answer opcode or address wrong");

  inv_length_a : assert property (frmEnd && !q_ff.clashFrame && q_ff.state == SER_IDLE && !hdrBad && !opcOk
    |=> {q_ff.rsp[4], q_ff.rsp[3]} == $past(q_ff.len))
    else $error("invalid answer length wrong");

  crc_answer_a : assert property (frmEnd && !q_ff.clashFrame && q_ff.state == SER_IDLE && hdrBad
    |=> q_ff.rsp[0] == `SER_OP_BADCRC && q_ff.state == SER_STAGE)
    else $error("header crc fault not answered");

  crc_fields_a : assert property (frmEnd && !q_ff.clashFrame && q_ff.state == SER_IDLE && hdrBad
    |=> {q_ff.rsp[4], q_ff.rsp[3], q_ff.rsp[2], q_ff.rsp[1]} == {$past(q_ff.len), $past(q_ff.addr)})
    else $error("crc answer fields wrong");

  data_crc_a : assert property (q_ff.commsErr |-> q_ff.reqValid && q_ff.state == SER_WAIT_APP
    && q_ff.opc == `SER_OP_WRITE)
    else $error("data crc fault reported outside a write");

  clash_keep_a : assert property (q_ff.clashFrame && q_ff.frame && q_ff.state == SER_READY
    |=> $stable(q_ff.rsp) && !q_ff.reqValid)
    else $error("pending answer disturbed by clash frame");

  staged_first_a : assert property ($rose(q_ff.irqOn) |-> q_ff.state == SER_READY
    && $past(q_ff.state, 2) == SER_STAGE && q_ff.rsp[5] == $past(txCrcOut, 2))
    else $error("interrupt before response staged");

  clash_next_a : assert property (frmEnd && !q_ff.clashFrame && q_ff.state == SER_IDLE
    && q_ff.clash && !hdrBad |=> q_ff.rsp[0] == `SER_OP_INVALID && !q_ff.clash ##0 !q_ff.reqValid)
    else $error("request after clash not refused");

  irq_quiet_a : assert property (frmStart |=> !q_ff.irqOn [*2])
    else $error("interrupt while select low");

  stage_len_a : assert property ($rose(q_ff.state == SER_STAGE) |-> ##5 q_ff.state == SER_READY)
    else $error("header staging not five steps");

  inv_cov : cover property (frmEnd && q_ff.state == SER_IDLE && !q_ff.clashFrame && !hdrBad && !opcOk);
  crc_cov : cover property (frmEnd && q_ff.state == SER_IDLE && !q_ff.clashFrame && hdrBad);
  clash_cov : cover property (frmEnd && q_ff.clashFrame && opcOk);
  err_cov : cover property (q_ff.commsErr);

endmodule
`default_nettype wire

/* logic/ser_pkg.sv */
// ==========================================================
// shared types
package ser_pkg;

  typedef logic [7:0] ser_byte_t;

  // staged response header, index 0 is sent first
  typedef logic [5:0][7:0] ser_rsp_t;

  typedef enum logic [1:0]
  {
    SER_IDLE,
    SER_WAIT_APP,
    SER_STAGE,
    SER_READY
  } ser_state_t;

endpackage

/* logic/ser_spi_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_defs.svh"

// ==========================================================
// spi mode 0 shifter on the host's clock
module ser_spi_link
(
  // spi pins
  input  wire logic             sclk,
  input  wire logic             ssN,
  input  wire logic             mosi,
  output logic                  miso,
  output logic                  misoOe,
  // from the core domain
  input  wire logic             rstLink,
  input  wire ser_pkg::ser_rsp_t txRsp,
  // to the core domain
  output ser_pkg::ser_byte_t    rxByte,
  output logic                  rxTgl
);
  import ser_pkg::*;

  typedef struct packed {
    logic [2:0] bitCnt;
    logic [2:0] byteIdx;
  } ser_cnt_t;

  typedef struct packed {
    logic [6:0] shift;
    ser_byte_t  rxByte;
    logic       rxTgl;
  } ser_rx_t;

  ser_cnt_t cnt_ff, nxt_cnt;
  ser_rx_t  rx_ff, nxt_rx;

  // ==========================================================
  // next state: bit position, byte index, received byte
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_cnt.bitCnt = cnt_ff.bitCnt + 3'h1;
    if (cnt_ff.bitCnt == 3'h7 && cnt_ff.byteIdx != `SER_RSP_BYTES)
      nxt_cnt.byteIdx = cnt_ff.byteIdx + 3'h1;
    nxt_rx.shift = {rx_ff.shift[5:0], mosi};
    if (cnt_ff.bitCnt == 3'h7)
    begin
      nxt_rx.rxByte = {rx_ff.shift, mosi};
      nxt_rx.rxTgl = ~rx_ff.rxTgl;        // one toggle per byte
    end
  end

  // frame counters clear while the select is high
  always_ff @(posedge sclk or posedge ssN)
  begin
    if (ssN)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  // toggle survives frame ends, so its reset is the core's
  always_ff @(posedge sclk or posedge rstLink)
  begin
    if (rstLink)
      rx_ff <= '0;
    else if (!ssN)
      rx_ff <= nxt_rx;
  end

  // ==========================================================
  // miso walks the staged header, zero past its end
  assign miso = (cnt_ff.byteIdx < `SER_RSP_BYTES) ? txRsp[cnt_ff.byteIdx][~cnt_ff.bitCnt] : 1'b0;
  assign misoOe = ~ssN;
  assign rxByte = rx_ff.rxByte;
  assign rxTgl = rx_ff.rxTgl;

endmodule
`default_nettype wire
